/* core/led_fault_detect_report.sv */
// Open-LED detection, auto output off and thermal shutdown with fault pin
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module led_fault_detect_report (
	input  wire logic                                  core_clk,
	input  wire logic                                  rst,
	input  wire logic                                  blanking,
	input  wire logic                                  latch_strobe,
	input  wire logic                                  shift_clock,
	input  wire logic                                  grayscale_clock,
	input  wire logic                                  thermal_shutdown,
	input  wire logic [lfdr_pkg::CHANNELS-1:0]         belowOpenThreshold,
	input  wire logic [lfdr_pkg::CHANNELS-1:0]         sinkRequest,
	input  wire logic [lfdr_pkg::CHANNELS*lfdr_pkg::GS_WIDTH-1:0] grayscaleValue,
	input  wire logic [lfdr_pkg::ADDR_WIDTH-1:0]       regAddr,
	input  wire logic [lfdr_pkg::DATA_WIDTH-1:0]       regWdata,
	input  wire logic                                  regWrite,
	input  wire logic                                  regRead,
	output logic      [lfdr_pkg::DATA_WIDTH-1:0]       regRdata,
	output logic      [lfdr_pkg::CHANNELS-1:0]         sinkOutput,
	output logic                                       fault_pin_n_out,
	output logic                                       fault_pin_n_oe,
	output logic                                       statusOut,
	output logic                                       irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                                armed;
		logic [lfdr_pkg::COUNT_WIDTH-1:0]    gsCount;
		logic [lfdr_pkg::CHANNELS-1:0]       open_led_flag;
		logic [lfdr_pkg::CHANNELS-1:0]       forcedOff;
		logic                                outEnable;
		logic                                thermal_error_flag;
		logic                                thermalOff;
		logic                                coolAtBlankRise;
		logic                                thermPend;
		logic                                loadPend;
		logic [lfdr_pkg::EVENTS-1:0]         status;
		logic [lfdr_pkg::EVENTS-1:0]         enable;
		logic                                detectOn;
		logic [lfdr_pkg::DATA_WIDTH-1:0]     rdata;
		logic [lfdr_pkg::CHANNELS-1:0]       sinkOutput;
		logic                                faultOe;
		logic                                irq;
	} lfdr_state_t;

	lfdr_state_t st;
	lfdr_state_t next_st;

	logic [lfdr_pkg::PIN_COUNT-1:0]      pinRaw;
	logic [lfdr_pkg::PIN_COUNT-1:0]      pinLevel;
	logic [lfdr_pkg::PIN_COUNT-1:0]      pinRise;
	logic [lfdr_pkg::PIN_COUNT-1:0]      pinFall;
	logic [lfdr_pkg::CHANNELS-1:0]       gsCheckable;
	logic [lfdr_pkg::CHANNELS-1:0]       sampledOpen;
	logic [lfdr_pkg::EVENTS-1:0]         events;
	logic                                blankLvl;
	logic                                hotLvl;
	logic                                checkEdge;
	logic                                thermEval;
	logic                                sinkAllow;

	lfdr_status_if statusLink ();

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// pins and comparators synchronised
	assign pinRaw = {belowOpenThreshold, thermal_shutdown, grayscale_clock,
		shift_clock, latch_strobe, blanking};

	lfdr_pin_sync #(
		.W (lfdr_pkg::PIN_COUNT)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.pinIn    (pinRaw),
		.level    (pinLevel),
		.rise     (pinRise),
		.fall     (pinFall)
	);

	assign blankLvl = pinLevel[lfdr_pkg::PIN_BLANK];
	assign hotLvl   = pinLevel[lfdr_pkg::PIN_HOT];

	// ****************************************
	// Per-channel sampling qualifiers
	// ****************************************
	genvar ch;
	generate
		for (ch = 0; ch < lfdr_pkg::CHANNELS; ch++) begin : g_chan
			assign gsCheckable[ch] =
				grayscaleValue[ch*lfdr_pkg::GS_WIDTH +: lfdr_pkg::GS_WIDTH]
				>= lfdr_pkg::GS_MIN_CHECK;
			assign sampledOpen[ch] = st.sinkOutput[ch] & gsCheckable[ch]
				& pinLevel[lfdr_pkg::PIN_BELOW + ch];
		end
	endgenerate

	// Pin edges arrive about two core cycles late; the check inherits that lag
	// The count stands one short of the check edge just before that edge
	assign checkEdge = st.armed & ~blankLvl & pinRise[lfdr_pkg::PIN_GRAYSCALE_CLOCK]
		& (st.gsCount == lfdr_pkg::CHECK_EDGE - 6'h01);
	assign thermEval = st.thermPend & pinFall[lfdr_pkg::PIN_SCLK];

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_st = st;
		events  = '0;
		sinkAllow = 1'b0;
		// Later assignments below take priority, so a set beats a clear, except for outEnable and forcedOff, where the clear wins

		if (pinFall[lfdr_pkg::PIN_BLANK]) begin
			next_st.armed   = 1'b1;
			next_st.gsCount = '0;
		end else if (pinRise[lfdr_pkg::PIN_BLANK]) begin
			// A period cut short by blanking never reaches its check
			next_st.armed = 1'b0;
		end else if (st.armed & ~blankLvl & pinRise[lfdr_pkg::PIN_GRAYSCALE_CLOCK]) begin
			if (checkEdge) begin
				next_st.armed = 1'b0;
			end else begin
				next_st.gsCount = st.gsCount + 6'h01;
			end
		end

		// flags change only on the check edge
		if (checkEdge & st.detectOn) begin
			next_st.open_led_flag = sampledOpen;
			events[lfdr_pkg::EV_OPEN] = |sampledOpen;
		end

		// faulty sinks off until blank falls
		if (pinFall[lfdr_pkg::PIN_BLANK]) begin
			next_st.forcedOff = '0;
		end else if (checkEdge & st.detectOn) begin
			next_st.forcedOff = st.forcedOff | sampledOpen;
		end

		// blanking disables; first grayscale edge enables
		if (blankLvl) begin
			next_st.outEnable = 1'b0;
		end else if (pinRise[lfdr_pkg::PIN_GRAYSCALE_CLOCK]) begin
			next_st.outEnable = 1'b1;
		end

		if (pinRise[lfdr_pkg::PIN_BLANK]) begin
			next_st.coolAtBlankRise = ~hotLvl;
		end
		if (pinFall[lfdr_pkg::PIN_BLANK] & st.coolAtBlankRise & ~hotLvl) begin
			next_st.thermalOff = 1'b0;
		end

		// re-evaluate after latch then shift fall
		if (pinFall[lfdr_pkg::PIN_LATCH]) begin
			next_st.thermPend = 1'b1;
		end else if (thermEval) begin
			next_st.thermPend = 1'b0;
		end
		if (thermEval & ~hotLvl & st.thermal_error_flag) begin
			next_st.thermal_error_flag = 1'b0;
			events[lfdr_pkg::EV_THERM_CLEAR] = 1'b1;
		end

		if (hotLvl) begin
			next_st.thermal_error_flag = 1'b1;
			next_st.thermalOff         = 1'b1;
			events[lfdr_pkg::EV_THERM_SET] = ~st.thermal_error_flag;
		end

		// first shift rise after latch loads
		if (pinFall[lfdr_pkg::PIN_LATCH]) begin
			next_st.loadPend = 1'b1;
		end else if (pinRise[lfdr_pkg::PIN_SCLK]) begin
			next_st.loadPend = 1'b0;
		end

		// sink gating, thermal and open faults
		// Live hot level is included so shutdown does not wait a cycle for the flag
		sinkAllow = next_st.outEnable & ~next_st.thermalOff & ~hotLvl & ~blankLvl;
		next_st.sinkOutput = sinkAllow ? (sinkRequest & ~next_st.forcedOff) : '0;

		// pin driven in the setting edge
		next_st.faultOe = next_st.thermal_error_flag
			| ((|next_st.open_led_flag) & ~blankLvl);

		// Register writes; a clear never hides an event in the same cycle
		if (regWrite) begin
			case (regAddr)
				lfdr_pkg::REG_CLEAR: begin
					next_st.status = st.status & ~regWdata[lfdr_pkg::EVENTS-1:0];
				end
				lfdr_pkg::REG_ENABLE: begin
					next_st.enable = regWdata[lfdr_pkg::EVENTS-1:0];
				end
				lfdr_pkg::REG_CTRL: begin
					next_st.detectOn = regWdata[lfdr_pkg::CTRL_DETECT];
				end
				lfdr_pkg::REG_FLAGS, lfdr_pkg::REG_STATUS: begin
					// Read-only: writes are dropped
				end
				default: begin
				end
			endcase
		end
		next_st.status = next_st.status | events;
		next_st.irq    = |(next_st.status & next_st.enable);

		// Read data stand for one cycle only; unmapped reads return zero
		next_st.rdata = '0;
		if (regRead) begin
			case (regAddr)
				lfdr_pkg::REG_FLAGS: begin
					next_st.rdata[lfdr_pkg::STATUS_BITS-1:0] =
						{st.thermal_error_flag, st.open_led_flag};
				end
				lfdr_pkg::REG_STATUS: begin
					next_st.rdata[lfdr_pkg::EVENTS-1:0] = st.status;
				end
				lfdr_pkg::REG_ENABLE: begin
					next_st.rdata[lfdr_pkg::EVENTS-1:0] = st.enable;
				end
				lfdr_pkg::REG_CTRL: begin
					next_st.rdata[lfdr_pkg::CTRL_DETECT] = st.detectOn;
				end
				lfdr_pkg::REG_CLEAR: begin
					// Write-only: reads see zero
					next_st.rdata = '0;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Flags have no defined power-up value in the part; zero is chosen here
	// Detection starts on so a controller that never writes CTRL still sees flags
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st          <= '0;
			st.enable   <= lfdr_pkg::ENABLE_RESET;
			st.detectOn <= lfdr_pkg::DETECT_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Status readback shifter
	// ****************************************
	assign statusLink.loadPulse  = st.loadPend & pinRise[lfdr_pkg::PIN_SCLK];
	assign statusLink.shiftPulse = pinRise[lfdr_pkg::PIN_SCLK];
	assign statusLink.statusReadbackWord = {st.open_led_flag, st.thermal_error_flag};

	lfdr_status_shift u_shift (
		.core_clk (core_clk),
		.rst      (rst),
		.link     (statusLink.shifter)
	);

	// ****************************************
	// Outputs
	// ****************************************
	// open-drain pin only ever pulls low
	assign regRdata        = st.rdata;
	assign sinkOutput      = st.sinkOutput;
	assign fault_pin_n_out = 1'b0;
	assign fault_pin_n_oe  = st.faultOe;
	assign statusOut       = statusLink.serialOut;
	assign irq             = st.irq;
endmodule : led_fault_detect_report
`default_nettype wire

/* core/lfdr_pin_sync.sv */
// Two-flop synchroniser with edge detection for outside pins
`timescale 1ns/1ps
`default_nettype none
module lfdr_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
		logic [W-1:0] prev;
		logic [2:0]   filled;
	} lfdr_sync_t;

	lfdr_sync_t st;
	lfdr_sync_t next_st;

	// Only the second stage and later feed logic
	always_comb begin
		next_st.meta   = pinIn;
		next_st.stable = st.meta;
		next_st.prev   = st.stable;
		next_st.filled = {st.filled[1:0], 1'b1};
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.stable;
	// Edges are masked until all stages hold real samples, so a pin that idles
	// high does not show a false rise after reset; edges in that window are lost
	assign rise  = st.stable & ~st.prev & {W{st.filled[2]}};
	assign fall  = ~st.stable & st.prev & {W{st.filled[2]}};
endmodule : lfdr_pin_sync
`default_nettype wire

/* core/lfdr_pkg.sv */
// Constants shared by the LED fault detection and reporting block
package lfdr_pkg;
	// ****************************************
	// Channel and word sizes
	// ****************************************
	localparam int CHANNELS     = 16;
	localparam int GS_WIDTH     = 16;
	localparam int STATUS_BITS  = CHANNELS + 1;
	localparam int ADDR_WIDTH   = 8;
	localparam int DATA_WIDTH   = 32;
	localparam int COUNT_WIDTH  = 6;

	// ****************************************
	// Detection timing and thresholds
	// ****************************************
	// Grayscale edge of each display period on which outputs are checked
	localparam logic [COUNT_WIDTH-1:0] CHECK_EDGE   = 6'h21;
	// Smallest grayscale value for which an open flag may be reported
	localparam logic [GS_WIDTH-1:0]    GS_MIN_CHECK = 16'h1001;

	// ****************************************
	// Synchronised pin positions
	// ****************************************
	localparam int PIN_BLANK   = 0;
	localparam int PIN_LATCH   = 1;
	localparam int PIN_SCLK    = 2;
	localparam int PIN_GRAYSCALE_CLOCK   = 3;
	localparam int PIN_HOT     = 4;
	localparam int PIN_BELOW   = 5;
	localparam int PIN_COUNT   = PIN_BELOW + CHANNELS;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [ADDR_WIDTH-1:0] REG_FLAGS  = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] REG_CLEAR  = 8'h08;
	localparam logic [ADDR_WIDTH-1:0] REG_ENABLE = 8'h0c;
	localparam logic [ADDR_WIDTH-1:0] REG_CTRL   = 8'h10;

	// ****************************************
	// Event bits and reset values
	// ****************************************
	localparam int EVENTS         = 3;
	localparam int EV_OPEN        = 0;
	localparam int EV_THERM_SET   = 1;
	localparam int EV_THERM_CLEAR = 2;
	localparam int CTRL_DETECT    = 0;
	localparam logic [EVENTS-1:0] ENABLE_RESET = 3'h0;
	localparam logic              DETECT_RESET = 1'h1;
endpackage : lfdr_pkg

/* core/lfdr_status_if.sv */
// Link between the fault logic and the status readback shifter
`timescale 1ns/1ps
`default_nettype none
interface lfdr_status_if;
	logic                              loadPulse;
	logic                              shiftPulse;
	logic [lfdr_pkg::STATUS_BITS-1:0]  statusReadbackWord;
	logic                              serialOut;

	modport core (
		output loadPulse,
		output shiftPulse,
		output statusReadbackWord,
		input  serialOut
	);
	modport shifter (
		input  loadPulse,
		input  shiftPulse,
		input  statusReadbackWord,
		output serialOut
	);
endinterface : lfdr_status_if
`default_nettype wire

/* core/lfdr_status_shift.sv */
// Serial readback of the open and thermal flags on the shift clock
`timescale 1ns/1ps
`default_nettype none
module lfdr_status_shift (
	input  wire logic   core_clk,
	input  wire logic   rst,
	lfdr_status_if.shifter link
);
	typedef struct packed {
		logic [lfdr_pkg::STATUS_BITS-1:0] shiftReg;
		logic                             serialOut;
	} lfdr_shift_t;

	lfdr_shift_t st;
	lfdr_shift_t next_st;

	always_comb begin
		next_st = st;
		if (link.loadPulse) begin
			next_st.shiftReg = link.statusReadbackWord;
		end else if (link.shiftPulse) begin
			next_st.shiftReg = {st.shiftReg[lfdr_pkg::STATUS_BITS-2:0], 1'b0};
		end
		next_st.serialOut = next_st.shiftReg[lfdr_pkg::STATUS_BITS-1];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign link.serialOut = st.serialOut;
endmodule : lfdr_status_shift
`default_nettype wire

/* test/lfdr_ctrl_model.sv */
// Display controller model driving blanking, latch, shift and grayscale pins
`timescale 1ns/1ps
`default_nettype none
module lfdr_ctrl_model (
	output logic      blanking,
	output logic      latch_strobe,
	output logic      shift_clock,
	output logic      grayscale_clock,
	input  wire logic statusOut
);
	initial begin
		blanking = 1'h1;
		latch_strobe = 1'h0;
		shift_clock = 1'h0;
		grayscale_clock = 1'h0;
	end
	// Grayscale clock stands still outside a display period
	task automatic run(input int n);
		blanking = 1'h0;
		#100;
		repeat (n) begin
			grayscale_clock = 1'h1;
			#40;
			grayscale_clock = 1'h0;
			#40;
		end
		#100;
	endtask : run
	task automatic blank();
		blanking = 1'h1;
		#100;
	endtask : blank
	task automatic readback(output logic [16:0] w);
		latch_strobe = 1'h1;
		#80;
		latch_strobe = 1'h0;
		#80;
		for (int i = 16; i >= 0; i--) begin
			shift_clock = 1'h1;
			#80;
			w[i] = statusOut;
			shift_clock = 1'h0;
			#80;
		end
	endtask : readback
endmodule : lfdr_ctrl_model
`default_nettype wire

/* test/lfdr_props.sv */
// Port checks for the fault detection block
`timescale 1ns/1ps
`default_nettype none
module lfdr_props (
	input wire logic                     core_clk,
	input wire logic                     rst,
	input wire logic                     blanking,
	input wire logic                     thermal_shutdown,
	input wire logic [lfdr_pkg::CHANNELS-1:0] sinkRequest,
	input wire logic [lfdr_pkg::CHANNELS-1:0] sinkOutput,
	input wire logic                     fault_pin_n_out,
	input wire logic                     fault_pin_n_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Eight samples is safely past the two-flop pin delay
	sequence blankHeld; blanking[*8]; endsequence
	sequence hotHeld; thermal_shutdown[*8]; endsequence
	sequence hotStart; $rose(thermal_shutdown); endsequence
	blank_sinks_off_a: assert property (blankHeld |-> sinkOutput == '0)
		else $error("sink on while blanked");
	hot_sinks_off_a: assert property (hotHeld |-> sinkOutput == '0)
		else $error("sink on while hot");
	hot_pin_rise_a: assert property (hotStart |-> ##[1:6] fault_pin_n_oe)
		else $error("pin not driven after over-temperature");
	hot_pin_hold_a: assert property (hotHeld |-> fault_pin_n_oe)
		else $error("pin released while hot");
	hot_blank_pin_a: assert property (hotHeld ##0 blankHeld |-> fault_pin_n_oe)
		else $error("pin released by blanking while hot");
	pin_cool_fall_a: assert property ($fell(fault_pin_n_oe) |-> !$past(thermal_shutdown, 3))
		else $error("pin released with detector hot");
	pin_drive_low_a: assert property (fault_pin_n_out == 1'h0)
		else $error("open drain pin driven high");
	sink_needs_req_a: assert property ((sinkOutput & ~$past(sinkRequest)) == '0)
		else $error("sink on without request");
endmodule : lfdr_props
bind led_fault_detect_report lfdr_props i_lfdr_props (.core_clk, .rst, .blanking,
	.thermal_shutdown, .sinkRequest, .sinkOutput, .fault_pin_n_out, .fault_pin_n_oe);
`default_nettype wire

/* test/test_led_fault_detect_report.sv */
// Self-checking bench for the fault detection and reporting block
`timescale 1ns/1ps
`default_nettype none
module test_led_fault_detect_report;
	logic         core_clk = 1'h0;
	logic         rst = 1'h1;
	logic         hot = 1'h0;
	logic [15:0]  below = 16'h0;
	logic [15:0]  req = 16'h0;
	logic [255:0] gs = 256'h0;
	logic [7:0]   addr = 8'h0;
	logic [31:0]  wdata = 32'h0;
	logic         wr = 1'h0;
	logic         rd = 1'h0;
	logic [31:0]  rdata;
	logic [15:0]  sink;
	logic         pinOut;
	logic         pinOe;
	logic         sout;
	logic         irq;
	logic         blank;
	logic         latch;
	logic         sclk;
	logic         gclk;
	logic [16:0]  word;
	logic [15:0]  expOpen;
	int           fails = 0;
	int           n_tests = 0;
	// Pull-up holds the pin high whenever nobody sinks it
	wire          faultPinN = pinOe ? pinOut : 1'h1;
	always #5 core_clk = ~core_clk;
	led_fault_detect_report i_led_fault_detect_report (.core_clk(core_clk), .rst(rst),
		.blanking(blank), .latch_strobe(latch), .shift_clock(sclk), .grayscale_clock(gclk),
		.thermal_shutdown(hot), .belowOpenThreshold(below), .sinkRequest(req),
		.grayscaleValue(gs), .regAddr(addr), .regWdata(wdata), .regWrite(wr), .regRead(rd),
		.regRdata(rdata), .sinkOutput(sink), .fault_pin_n_out(pinOut),
		.fault_pin_n_oe(pinOe), .statusOut(sout), .irq(irq));
	lfdr_ctrl_model i_lfdr_ctrl_model (.blanking(blank), .latch_strobe(latch),
		.shift_clock(sclk), .grayscale_clock(gclk), .statusOut(sout));
	function automatic logic [15:0] openExp(logic [15:0] b, logic [15:0] r, logic [255:0] g);
		for (int c = 0; c < 16; c++)
			openExp[c] = b[c] && r[c] && (g[c*16 +: 16] >= 16'h1001);
	endfunction : openExp
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge core_clk);
		wr <= 1'h0;
	endtask : regWr
	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge core_clk);
		rd <= 1'h0;
		#1;
		chk(what, rdata, e);
	endtask : rdChk
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		#500000;
		fails++;
		finish_test();
	end
	initial begin
		void'($urandom(32'h6f36));
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		cyc(4);
		rdChk("flags", 8'h00, 32'h0);
		rdChk("status", 8'h04, 32'h0);
		rdChk("enable", 8'h0c, 32'h0);
		rdChk("ctrl", 8'h10, 32'h1);
		rdChk("unmapped", 8'h14, 32'h0);
		$display("test reset done");
		// Channels 0 and 1 straddle the grayscale threshold; channel 15 stays off
		@(posedge core_clk);
		below <= 16'($urandom) | 16'h3;
		req <= 16'h7fff;
		for (int c = 0; c < 16; c++)
			gs[c*16 +: 16] <= (c < 2) ? 16'h1000 + 16'(c) : 16'($urandom);
		regWr(8'h0c, 32'h7);
		i_lfdr_ctrl_model.run(32);
		rdChk("flags at 32", 8'h00, 32'h0);
		i_lfdr_ctrl_model.blank();
		i_lfdr_ctrl_model.run(33);
		// Flags trusted only after a lit period
		expOpen = openExp(below, req, gs);
		rdChk("flags at 33", 8'h00, {16'h0, expOpen});
		chk("forced off", sink, req & ~expOpen);
		chk("open pin", faultPinN, 1'h0);
		@(posedge core_clk);
		below <= 16'h0;
		i_lfdr_ctrl_model.blank();
		rdChk("flags held", 8'h00, {16'h0, expOpen});
		chk("pin in blank", faultPinN, 1'h1);
		chk("blank sinks", sink, 16'h0);
		rdChk("open event", 8'h04, 32'h1);
		chk("irq on", irq, 1'h1);
		regWr(8'h0c, 32'h0);
		cyc(2);
		chk("irq masked", irq, 1'h0);
		regWr(8'h08, 32'h7);
		rdChk("status cleared", 8'h04, 32'h0);
		$display("test open detection done");
		i_lfdr_ctrl_model.run(4);
		@(posedge core_clk);
		hot <= 1'h1;
		cyc(8);
		chk("hot sinks", sink, 16'h0);
		chk("hot pin", faultPinN, 1'h0);
		rdChk("hot flag", 8'h00, {15'h0, 1'h1, expOpen});
		i_lfdr_ctrl_model.blank();
		chk("hot pin blank", faultPinN, 1'h0);
		i_lfdr_ctrl_model.readback(word);
		chk("readback", word, {expOpen, 1'h1});
		rdChk("flag while hot", 8'h00, {15'h0, 1'h1, expOpen});
		@(posedge core_clk);
		hot <= 1'h0;
		cyc(8);
		rdChk("flag kept cool", 8'h00, {15'h0, 1'h1, expOpen});
		i_lfdr_ctrl_model.readback(word);
		chk("readback cool", word, {expOpen, 1'h1});
		rdChk("flag cleared", 8'h00, {16'h0, expOpen});
		chk("pin released", faultPinN, 1'h1);
		rdChk("thermal events", 8'h04, 32'h6);
		// Previous blanking rise came while hot, so this period stays dark
		i_lfdr_ctrl_model.run(2);
		chk("no restart", sink, 16'h0);
		i_lfdr_ctrl_model.blank();
		i_lfdr_ctrl_model.run(40);
		chk("restart", sink, req);
		rdChk("resampled", 8'h00, 32'h0);
		i_lfdr_ctrl_model.blank();
		$display("test thermal done");
		// Detection switched off: flags hold and no sink is forced off
		@(posedge core_clk);
		below <= 16'hffff;
		regWr(8'h10, 32'h0);
		i_lfdr_ctrl_model.run(40);
		rdChk("detect off", 8'h00, 32'h0);
		chk("no auto off", sink, req);
		chk("no open pin", faultPinN, 1'h1);
		rdChk("ctrl off", 8'h10, 32'h0);
		i_lfdr_ctrl_model.blank();
		$display("test detect off done");
		finish_test();
	end
endmodule : test_led_fault_detect_report
`default_nettype wire
